/* core/apd_pkg.sv */
// Purpose: Shared constants and types of the addressing-mode and prefix-byte decoder.
// Assumes: Byte-wide program/data memory with a 16-bit address space.
// Notes: The opcode column layout lives in the classifier.
package apd_pkg;

    localparam logic [7:0] PFX_SECOND_INDEX_BYTE = 8'h90;
    localparam logic [7:0] PFX_SECOND_INDEX_INDIRECT_BYTE = 8'h91;
    localparam logic [7:0] PFX_INDIRECT_BYTE = 8'h92;
    // Relative call sits in the immediate column and is pulled out by value
    localparam logic [7:0] OP_RELATIVE_CALL = 8'had;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [2:0] LEN_STEP = 3'h1;
    localparam logic [1:0] CNT_STEP = 2'h1;

    typedef enum logic [1:0] {
        PFX_NONE,
        PFX_Y,
        PFX_IND,
        PFX_IND_Y
    } apd_pfx_type;

    typedef enum logic [4:0] {
        MODE_INH,
        MODE_IMM,
        MODE_DIR_S,
        MODE_DIR_L,
        MODE_IDX0,
        MODE_IDX_S,
        MODE_IDX_L,
        MODE_IND_S,
        MODE_IND_L,
        MODE_IIDX_S,
        MODE_IIDX_L,
        MODE_REL,
        MODE_REL_IND,
        MODE_BIT_DIR,
        MODE_BIT_IND,
        MODE_BTJ_DIR,
        MODE_BTJ_IND
    } apd_mode_type;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_CLASSIFY,
        ST_EXTENSION,
        ST_POINTER,
        ST_RESOLVE,
        ST_HANDOFF
    } apd_state_type;

endpackage : apd_pkg

/* core/apd_dec_if.sv */
// Purpose: Carries opcode, mode and address terms between the decoder's modules.
// Assumes: Purely combinational paths across it.
// Notes: cls feeds the mode, agu forms the addresses, core owns the state.
`timescale 1ns/1ps
`default_nettype none
interface apd_dec_if;
    import apd_pkg::*;
    logic [7:0] opcode;
    apd_pfx_type pfx;
    apd_mode_type mode;
    logic use_y;
    logic [1:0] ext_len;
    logic [1:0] ptr_len;
    logic [7:0] ix;
    logic [7:0] iy;
    logic [7:0] ext0;
    logic [7:0] ext1;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [15:0] next_pc;
    logic [15:0] ea;
    logic [15:0] target;

    modport cls (input opcode, pfx, output mode, use_y, ext_len, ptr_len);
    modport agu (input mode, use_y, ix, iy, ext0, ext1, ptr0, ptr1, next_pc,
                 output ea, target);
    modport core (output opcode, pfx, ix, iy, ext0, ext1, ptr0, ptr1, next_pc,
                  input mode, use_y, ext_len, ptr_len, ea, target);
endinterface : apd_dec_if
`default_nettype wire

/* core/apd_classify.sv */
// Purpose: Maps opcode and prefix to addressing mode, index choice and byte counts.
// Assumes: Opcode column (high nibble) selects the base mode.
// Notes: A prefix that does not apply to the base mode leaves it unchanged.
`timescale 1ns/1ps
`default_nettype none
module apd_classify (
    apd_dec_if.cls dif
);
    import apd_pkg::*;

    apd_mode_type base;

    always_comb begin
        unique case (dif.opcode[7:4])
            4'h0: base = MODE_BTJ_DIR;
            4'h1: base = MODE_BIT_DIR;
            4'h2: base = MODE_REL;
            4'h3, 4'hb: base = MODE_DIR_S;
            4'h4, 4'h5, 4'h8, 4'h9: base = MODE_INH;
            4'h6, 4'he: base = MODE_IDX_S;
            4'h7, 4'hf: base = MODE_IDX0;
            4'ha: base = MODE_IMM;
            4'hc: base = MODE_DIR_L;
            4'hd: base = MODE_IDX_L;
        endcase
        if (dif.opcode == OP_RELATIVE_CALL) begin
            base = MODE_REL;
        end
        dif.mode = base;
        dif.use_y = 1'b0;
        unique case (dif.pfx)
            PFX_NONE: dif.use_y = 1'b0;
            PFX_Y: dif.use_y = base inside {MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_INH,
                                            MODE_IDX0, MODE_IDX_S, MODE_IDX_L};
            PFX_IND: begin
                unique case (base)
                    MODE_DIR_S: dif.mode = MODE_IND_S;
                    MODE_DIR_L: dif.mode = MODE_IND_L;
                    MODE_REL: dif.mode = MODE_REL_IND;
                    MODE_BIT_DIR: dif.mode = MODE_BIT_IND;
                    MODE_BTJ_DIR: dif.mode = MODE_BTJ_IND;
                    MODE_IDX_S: dif.mode = MODE_IIDX_S;
                    MODE_IDX_L: dif.mode = MODE_IIDX_L;
                    default: dif.mode = base;
                endcase
            end
            PFX_IND_Y: begin
                if (base inside {MODE_IDX_S, MODE_IDX_L}) begin
                    dif.mode = (base == MODE_IDX_S) ? MODE_IIDX_S : MODE_IIDX_L;
                    dif.use_y = 1'b1;
                end
            end
        endcase
        // Bytes after the opcode, then pointer bytes read from page zero
        unique case (dif.mode)
            MODE_INH, MODE_IDX0: dif.ext_len = 2'd0;
            MODE_DIR_L, MODE_IDX_L, MODE_BTJ_DIR, MODE_BTJ_IND: dif.ext_len = 2'd2;
            default: dif.ext_len = 2'd1;
        endcase
        unique case (dif.mode)
            MODE_IND_L, MODE_IIDX_L: dif.ptr_len = 2'd2;
            MODE_IND_S, MODE_IIDX_S, MODE_REL_IND, MODE_BIT_IND,
            MODE_BTJ_IND: dif.ptr_len = 2'd1;
            default: dif.ptr_len = 2'd0;
        endcase
    end

endmodule : apd_classify
`default_nettype wire

/* core/apd_agu.sv */
// Purpose: Forms the effective address and the relative branch target.
// Assumes: Two-byte fields are high byte first.
// Notes: Index additions are unsigned and never wrap below 64 KB.
`timescale 1ns/1ps
`default_nettype none
module apd_agu (
    apd_dec_if.agu dif
);
    import apd_pkg::*;

    logic [15:0] idx;
    logic [7:0] off;

    always_comb begin
        idx = {PAGE_ZERO_HI, (dif.use_y ? dif.iy : dif.ix)};
        unique case (dif.mode)
            MODE_IMM, MODE_INH, MODE_REL, MODE_REL_IND: dif.ea = 16'h0000;
            MODE_DIR_S, MODE_BIT_DIR, MODE_BTJ_DIR: dif.ea = {PAGE_ZERO_HI, dif.ext0};
            MODE_DIR_L: dif.ea = {dif.ext0, dif.ext1};
            MODE_IDX0: dif.ea = idx;
            MODE_IDX_S: dif.ea = {PAGE_ZERO_HI, dif.ext0} + idx;
            MODE_IDX_L: dif.ea = {dif.ext0, dif.ext1} + idx;
            MODE_IND_S, MODE_BIT_IND, MODE_BTJ_IND: dif.ea = {PAGE_ZERO_HI, dif.ptr0};
            MODE_IND_L: dif.ea = {dif.ptr0, dif.ptr1};
            MODE_IIDX_S: dif.ea = {PAGE_ZERO_HI, dif.ptr0} + idx;
            MODE_IIDX_L: dif.ea = {dif.ptr0, dif.ptr1} + idx;
        endcase
        unique case (dif.mode)
            MODE_REL_IND: off = dif.ptr0;
            MODE_BTJ_DIR, MODE_BTJ_IND: off = dif.ext1;
            default: off = dif.ext0;
        endcase
        // Base is the address after the whole instruction
        dif.target = dif.next_pc + {{8{off[7]}}, off};
    end

endmodule : apd_agu
`default_nettype wire

/* core/apd_decoder.sv */
// Purpose: Fetches prefix, opcode, address bytes and pointers; hands a decoded instruction on.
// Assumes: Memory answers a held read request with mem_ack and data in the same cycle.
// Notes: One instruction in flight; the executor takes it with exec_ready.
// Functional notes
// - Inherent instructions are the opcode alone, no further bytes.
// - Immediate takes exactly one byte after the opcode as operand value.
// - Short direct uses one address byte, so addresses stay in 00..FF.
// - Long direct fetches a two-byte address covering 64 KB.
// - Indexed address is unsigned sum of chosen index register and offset.
// - Indexed without offset adds no byte; address equals index register.
// - Short indexed adds one unsigned offset byte, reaching up to 1FE.
// - Long indexed fetches a two-byte offset covering 64 KB.
// - Indirect reads a page-zero pointer address, then fetches the pointer.
// - Short indirect pointer is one byte; long indirect pointer is two.
// - Indirect indexed address is index register plus fetched pointer.
// - Short indirect indexed reaches 1FE; long variant covers 64 KB.
// - Relative jumps and relative call add a signed 8-bit offset.
// - Relative indirect fetches the signed offset from the given address.
// - Instructions span one to four bytes including any prefix.
// - Optional prefix, opcode, then zero to two address bytes.
// - Prefix 90 swaps first index register for the second.
// - Prefix 92 turns direct forms indirect and indexed into indirect indexed.
// - Prefix 91 makes first-index indirect indexed use the second index.
// - Relative target is based on the address after the jump.
`timescale 1ns/1ps
`default_nettype none
module apd_decoder (
    input wire logic ref_clk,
    input wire logic rst,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] idx_first,
    input wire logic [7:0] idx_second,
    input wire logic exec_ready,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    output logic dec_valid,
    output logic [7:0] dec_opcode,
    output apd_pkg::apd_mode_type dec_mode,
    output logic dec_use_y,
    output logic [2:0] dec_len,
    output logic [7:0] dec_operand,
    output logic [15:0] dec_ea,
    output logic [15:0] dec_target,
    output logic [15:0] dec_next_pc
);
    import apd_pkg::*;

    typedef struct packed {
        apd_state_type st;
        logic [15:0] pc;
        logic mem_req;
        logic [15:0] mem_addr;
        apd_pfx_type pfx;
        logic [7:0] opcode;
        logic [7:0] ext0;
        logic [7:0] ext1;
        logic [7:0] ptr0;
        logic [7:0] ptr1;
        logic [1:0] cnt;
        logic [2:0] len;
        logic dec_valid;
        apd_mode_type dec_mode;
        logic dec_use_y;
        logic [2:0] dec_len;
        logic [7:0] dec_operand;
        logic [15:0] dec_ea;
        logic [15:0] dec_target;
        logic [15:0] dec_next_pc;
    } apd_core_type;

    localparam apd_core_type CORE_RESET = '{st: ST_OPCODE, pfx: PFX_NONE, dec_mode: MODE_INH,
                                            pc: RESET_PC, default: '0};

    apd_core_type r_reg;
    apd_core_type r_next;
    apd_pfx_type byte_pfx;
    logic got;
    logic [15:0] ptr_addr;
    logic [1:0] cnt_inc;

    apd_dec_if dif ();

    apd_classify u_classify (
        .dif(dif.cls)
    );

    apd_agu u_agu (
        .dif(dif.agu)
    );

    assign dif.opcode = r_reg.opcode;
    assign dif.pfx = r_reg.pfx;
    assign dif.ix = idx_first;
    assign dif.iy = idx_second;
    assign dif.ext0 = r_reg.ext0;
    assign dif.ext1 = r_reg.ext1;
    assign dif.ptr0 = r_reg.ptr0;
    assign dif.ptr1 = r_reg.ptr1;
    assign dif.next_pc = r_reg.pc;

    always_comb begin
        unique case (mem_rdata)
            PFX_SECOND_INDEX_BYTE: byte_pfx = PFX_Y;
            PFX_INDIRECT_BYTE: byte_pfx = PFX_IND;
            PFX_SECOND_INDEX_INDIRECT_BYTE: byte_pfx = PFX_IND_Y;
            default: byte_pfx = PFX_NONE;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        got = r_reg.mem_req && mem_ack;
        cnt_inc = r_reg.cnt + CNT_STEP;
        // Pointers start in page zero; the 16-bit sum lets a two-byte pointer at FF carry its second byte to 0100
        ptr_addr = {PAGE_ZERO_HI, r_reg.ext0} + {14'h0000, r_reg.cnt};
        if (r_reg.st inside {ST_OPCODE, ST_EXTENSION, ST_POINTER}) begin
            if (!r_reg.mem_req) begin
                r_next.mem_req = 1'b1;
                r_next.mem_addr = (r_reg.st == ST_POINTER) ? ptr_addr : r_reg.pc;
            end else if (mem_ack) begin
                r_next.mem_req = 1'b0;
            end
        end
        unique case (r_reg.st)
            ST_OPCODE: begin
                if (got) begin
                    r_next.pc = r_reg.pc + PC_STEP;
                    r_next.len = r_reg.len + LEN_STEP;
                    // A second prefix byte is taken as an opcode, never stacked
                    if (r_reg.pfx == PFX_NONE && byte_pfx != PFX_NONE) begin
                        r_next.pfx = byte_pfx;
                    end else begin
                        r_next.opcode = mem_rdata;
                        r_next.st = ST_CLASSIFY;
                    end
                end
            end
            ST_CLASSIFY: begin
                r_next.cnt = 2'd0;
                if (dif.ext_len != 2'd0) begin
                    r_next.st = ST_EXTENSION;
                end else if (dif.ptr_len != 2'd0) begin
                    r_next.st = ST_POINTER;
                end else begin
                    r_next.st = ST_RESOLVE;
                end
            end
            ST_EXTENSION: begin
                if (got) begin
                    if (r_reg.cnt == 2'd0) begin
                        r_next.ext0 = mem_rdata;
                    end else begin
                        r_next.ext1 = mem_rdata;
                    end
                    r_next.pc = r_reg.pc + PC_STEP;
                    r_next.len = r_reg.len + LEN_STEP;
                    r_next.cnt = cnt_inc;
                    if (cnt_inc == dif.ext_len) begin
                        r_next.cnt = 2'd0;
                        r_next.st = (dif.ptr_len != 2'd0) ? ST_POINTER : ST_RESOLVE;
                    end
                end
            end
            ST_POINTER: begin
                if (got) begin
                    if (r_reg.cnt == 2'd0) begin
                        r_next.ptr0 = mem_rdata;
                    end else begin
                        r_next.ptr1 = mem_rdata;
                    end
                    r_next.cnt = cnt_inc;
                    if (cnt_inc == dif.ptr_len) begin
                        r_next.st = ST_RESOLVE;
                    end
                end
            end
            ST_RESOLVE: begin
                r_next.dec_valid = 1'b1;
                r_next.dec_mode = dif.mode;
                r_next.dec_use_y = dif.use_y;
                r_next.dec_len = r_reg.len;
                r_next.dec_operand = r_reg.ext0;
                r_next.dec_ea = dif.ea;
                r_next.dec_target = dif.target;
                r_next.dec_next_pc = r_reg.pc;
                r_next.st = ST_HANDOFF;
            end
            ST_HANDOFF: begin
                // The executor redirects the fetch here after a taken branch
                if (exec_ready) begin
                    r_next.dec_valid = 1'b0;
                    r_next.pc = pc_load ? pc_value : r_reg.pc;
                    r_next.pfx = PFX_NONE;
                    r_next.len = 3'd0;
                    r_next.st = ST_OPCODE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r_reg <= CORE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign mem_req = r_reg.mem_req;
    assign mem_addr = r_reg.mem_addr;
    assign dec_valid = r_reg.dec_valid;
    assign dec_opcode = r_reg.opcode;
    assign dec_mode = r_reg.dec_mode;
    assign dec_use_y = r_reg.dec_use_y;
    assign dec_len = r_reg.dec_len;
    assign dec_operand = r_reg.dec_operand;
    assign dec_ea = r_reg.dec_ea;
    assign dec_target = r_reg.dec_target;
    assign dec_next_pc = r_reg.dec_next_pc;

    // Checks on each freshly decoded instruction, on pointer reads and on the held output
    logic [2:0] pfx_len;
    assign pfx_len = (r_reg.pfx == PFX_NONE) ? 3'd0 : 3'd1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_inh_len;
        $rose(dec_valid) && dec_mode == MODE_INH |-> dec_len == pfx_len + 3'd1;
    endproperty
    a_inh_len: assert property (p_inh_len) else $error("inherent length wrong");

    property p_imm_operand;
        $rose(dec_valid) && dec_mode == MODE_IMM
            |-> dec_len == pfx_len + 3'd2 && dec_operand == r_reg.ext0;
    endproperty
    a_imm_operand: assert property (p_imm_operand) else $error("immediate operand wrong");

    property p_dir_short;
        $rose(dec_valid) && dec_mode == MODE_DIR_S |-> dec_ea[15:8] == 8'h00 && dec_len == pfx_len + 3'd2;
    endproperty
    a_dir_short: assert property (p_dir_short) else $error("short direct out of page zero");

    property p_long_len;
        $rose(dec_valid) && dec_mode inside {MODE_DIR_L, MODE_IDX_L} |-> dec_len == pfx_len + 3'd3;
    endproperty
    a_long_len: assert property (p_long_len) else $error("long form length wrong");

    property p_idx_short;
        $rose(dec_valid) && dec_mode == MODE_IDX_S
            |-> dec_ea == {8'h00, r_reg.ext0} + {8'h00, dec_use_y ? idx_second : idx_first};
    endproperty
    a_idx_short: assert property (p_idx_short) else $error("short indexed address wrong");

    property p_ptr_page_zero;
        r_reg.st == ST_POINTER && mem_req |-> mem_addr[15:8] == 8'h00;
    endproperty
    a_ptr_page_zero: assert property (p_ptr_page_zero) else $error("pointer read off page zero");

    property p_iidx_range;
        $rose(dec_valid) && dec_mode == MODE_IIDX_S |-> dec_ea <= 16'h01fe;
    endproperty
    a_iidx_range: assert property (p_iidx_range) else $error("indirect indexed beyond 1fe");

    property p_rel_target;
        $rose(dec_valid) && dec_mode == MODE_REL
            |-> dec_target == dec_next_pc + {{8{r_reg.ext0[7]}}, r_reg.ext0};
    endproperty
    a_rel_target: assert property (p_rel_target) else $error("relative target wrong");

    property p_len_range;
        $rose(dec_valid) |-> dec_len >= 3'd1 && dec_len <= 3'd4;
    endproperty
    a_len_range: assert property (p_len_range) else $error("instruction length outside 1..4");

    property p_second_index;
        $rose(dec_valid) && r_reg.pfx == PFX_Y && dec_mode == MODE_IDX0
            |-> dec_use_y && dec_ea == {8'h00, idx_second};
    endproperty
    a_second_index: assert property (p_second_index) else $error("second index not used");

    property p_ind_y;
        $rose(dec_valid) && r_reg.pfx == PFX_IND_Y && r_reg.opcode[7:4] == 4'he
            |-> dec_mode == MODE_IIDX_S && dec_use_y;
    endproperty
    a_ind_y: assert property (p_ind_y) else $error("prefix 91 not applied");

    property p_hold;
        dec_valid && !exec_ready |=> dec_valid && $stable(dec_ea) && $stable(dec_len);
    endproperty
    a_hold: assert property (p_hold) else $error("decoded output dropped early");

endmodule : apd_decoder
`default_nettype wire

/* sim/apd_mem_model.sv */
// Purpose: Behavioural program/data memory that answers the decoder's reads.
// Assumes: One read outstanding; ack_delay adds wait cycles to each read.
// Notes: Idle data toggles, so a stale byte never passes for a fresh one.
`timescale 1ns/1ps
`default_nettype none
module apd_mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    input wire logic [3:0] ack_delay
);
    logic [7:0] store [0:65535];
    logic [3:0] wait_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            wait_cnt <= 4'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= ack_delay) begin
            mem_ack <= 1'b1;
            mem_rdata <= store[mem_addr];
            wait_cnt <= 4'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : apd_mem_model
`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the addressing-mode and prefix decoder.
// Assumes: Executor always ready except in the stall test.
// Notes: Unwritten memory holds single-byte instructions.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import apd_pkg::*;
    typedef struct packed {
        apd_mode_type mode;
        logic [2:0] len;
        logic y;
        logic [15:0] ea;
        logic [15:0] tgt;
        logic [15:0] nxt;
    } apd_row_type;
    logic ref_clk, rst, mem_req, mem_ack, exec_ready, pc_load, dec_valid, dec_use_y;
    logic [15:0] mem_addr, pc_value, dec_ea, dec_target, dec_next_pc;
    logic [7:0] mem_rdata, idx_first, idx_second, dec_opcode, dec_operand;
    logic [2:0] dec_len;
    logic [3:0] ack_delay;
    apd_mode_type dec_mode;
    apd_row_type rows [0:20];
    int n_errors = 0;
    int total_checks = 0;
    logic [7:0] prog [0:41] = '{8'h9d, 8'ha6, 8'h55, 8'hb6, 8'h80, 8'hc6, 8'h12, 8'h34,
        8'hf6, 8'he6, 8'hff, 8'hd6, 8'h12, 8'h34, 8'h90, 8'he6, 8'h10, 8'h92, 8'hb6, 8'h80,
        8'h92, 8'hc6, 8'h82, 8'h92, 8'he6, 8'h84, 8'h91, 8'hd6, 8'h86, 8'h20, 8'h80,
        8'had, 8'h7f, 8'h92, 8'h20, 8'h88, 8'h92, 8'h01, 8'h89, 8'h05, 8'h10, 8'h40};

    apd_decoder uut (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .idx_first(idx_first),
        .idx_second(idx_second), .exec_ready(exec_ready), .pc_load(pc_load),
        .pc_value(pc_value), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
        .dec_mode(dec_mode), .dec_use_y(dec_use_y), .dec_len(dec_len),
        .dec_operand(dec_operand), .dec_ea(dec_ea), .dec_target(dec_target),
        .dec_next_pc(dec_next_pc));
    apd_mem_model mem (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ack_delay(ack_delay));

    always #2.5 ref_clk = ~ref_clk;

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task automatic chk_mode(input apd_mode_type exp, input apd_mode_type got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] dec_mode expected %0d seen %0d", exp, got);
        end
    endtask : chk_mode

    task automatic check_row(input int i);
        int k;
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (dec_valid !== 1'b1 && k < 100);
        chk_val("dec_valid", 16'h0001, {15'h0, dec_valid});
        chk_mode(rows[i].mode, dec_mode);
        chk_val("dec_len", {13'h0, rows[i].len}, {13'h0, dec_len});
        chk_val("dec_use_y", {15'h0, rows[i].y}, {15'h0, dec_use_y});
        chk_val("dec_ea", rows[i].ea, dec_ea);
        chk_val("dec_next_pc", rows[i].nxt, dec_next_pc);
        if (rows[i].mode inside {MODE_REL, MODE_REL_IND, MODE_BTJ_DIR, MODE_BTJ_IND}) begin
            chk_val("dec_target", rows[i].tgt, dec_target);
        end
        if (rows[i].mode == MODE_IMM) begin
            chk_val("dec_operand", 16'h0055, {8'h00, dec_operand});
            chk_val("dec_opcode", 16'h00a6, {8'h00, dec_opcode});
        end
    endtask : check_row

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        exec_ready = 1'b0;
        pc_load = 1'b0;
        pc_value = 16'h0000;
        idx_first = 8'hf0;
        idx_second = 8'h33;
        ack_delay = 4'h0;
        for (int a = 0; a < 65536; a++) mem.store[a] = (a < 42) ? prog[a] : 8'h9d;
        mem.store[16'h0080] = 8'hc5;
        mem.store[16'h0082] = 8'hab;
        mem.store[16'h0083] = 8'hcd;
        mem.store[16'h0084] = 8'hfe;
        mem.store[16'h0086] = 8'h10;
        mem.store[16'h0087] = 8'h00;
        mem.store[16'h0088] = 8'hfe;
        mem.store[16'h0089] = 8'h77;
        // Redirected code: bit-test-jump, bit indirect, second-index no offset
        mem.store[16'h0100] = 8'h00;
        mem.store[16'h0101] = 8'h40;
        mem.store[16'h0102] = 8'hfd;
        mem.store[16'h0103] = 8'h92;
        mem.store[16'h0104] = 8'h10;
        mem.store[16'h0105] = 8'h80;
        mem.store[16'h0106] = 8'h90;
        mem.store[16'h0107] = 8'hf6;
        rows[0] = '{MODE_INH, 3'h1, 1'b0, 16'h0000, 16'h0000, 16'h0001};
        rows[1] = '{MODE_IMM, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0003};
        rows[2] = '{MODE_DIR_S, 3'h2, 1'b0, 16'h0080, 16'h0000, 16'h0005};
        rows[3] = '{MODE_DIR_L, 3'h3, 1'b0, 16'h1234, 16'h0000, 16'h0008};
        rows[4] = '{MODE_IDX0, 3'h1, 1'b0, 16'h00f0, 16'h0000, 16'h0009};
        rows[5] = '{MODE_IDX_S, 3'h2, 1'b0, 16'h01ef, 16'h0000, 16'h000b};
        rows[6] = '{MODE_IDX_L, 3'h3, 1'b0, 16'h1324, 16'h0000, 16'h000e};
        rows[7] = '{MODE_IDX_S, 3'h3, 1'b1, 16'h0043, 16'h0000, 16'h0011};
        rows[8] = '{MODE_IND_S, 3'h3, 1'b0, 16'h00c5, 16'h0000, 16'h0014};
        rows[9] = '{MODE_IND_L, 3'h3, 1'b0, 16'habcd, 16'h0000, 16'h0017};
        rows[10] = '{MODE_IIDX_S, 3'h3, 1'b0, 16'h01ee, 16'h0000, 16'h001a};
        rows[11] = '{MODE_IIDX_L, 3'h3, 1'b1, 16'h1033, 16'h0000, 16'h001d};
        rows[12] = '{MODE_REL, 3'h2, 1'b0, 16'h0000, 16'hff9f, 16'h001f};
        rows[13] = '{MODE_REL, 3'h2, 1'b0, 16'h0000, 16'h00a0, 16'h0021};
        rows[14] = '{MODE_REL_IND, 3'h3, 1'b0, 16'h0000, 16'h0022, 16'h0024};
        rows[15] = '{MODE_BTJ_IND, 3'h4, 1'b0, 16'h0077, 16'h002d, 16'h0028};
        rows[16] = '{MODE_BIT_DIR, 3'h2, 1'b0, 16'h0040, 16'h0000, 16'h002a};
        rows[17] = '{MODE_BTJ_DIR, 3'h3, 1'b0, 16'h0040, 16'h0100, 16'h0103};
        rows[18] = '{MODE_BIT_IND, 3'h3, 1'b0, 16'h00c5, 16'h0000, 16'h0106};
        rows[19] = '{MODE_IDX0, 3'h2, 1'b1, 16'h0033, 16'h0000, 16'h0108};
        rows[20] = '{MODE_INH, 3'h1, 1'b0, 16'h0000, 16'h0000, 16'h002b};
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_val("mem_req", 16'h0000, {15'h0, mem_req});
        @(posedge ref_clk);
        rst <= 1'b0;
        exec_ready <= 1'b1;
        // Release edge itself still resets; the first request follows one edge later
        repeat (2) @(negedge ref_clk);
        chk_val("mem_req", 16'h0001, {15'h0, mem_req});
        chk_val("mem_addr", 16'h0000, mem_addr);
        for (int i = 0; i < 17; i++) begin
            check_row(i);
            @(posedge ref_clk);
        end
        exec_ready <= 1'b0;
        check_row(20);
        // Unserved instruction must stand while the executor stalls
        repeat (4) begin
            @(negedge ref_clk);
            chk_val("dec_valid", 16'h0001, {15'h0, dec_valid});
            chk_val("dec_next_pc", 16'h002b, dec_next_pc);
            chk_val("dec_opcode", 16'h009d, {8'h00, dec_opcode});
        end
        @(posedge ref_clk);
        exec_ready <= 1'b1;
        pc_load <= 1'b1;
        pc_value <= 16'h0003;
        ack_delay <= 4'h3;
        @(posedge ref_clk);
        pc_load <= 1'b0;
        @(negedge ref_clk);
        chk_val("dec_valid", 16'h0000, {15'h0, dec_valid});
        @(negedge ref_clk);
        chk_val("mem_addr", 16'h0003, mem_addr);
        check_row(2);
        @(posedge ref_clk);
        rst <= 1'b1;
        ack_delay <= 4'h0;
        @(negedge ref_clk);
        chk_val("dec_valid", 16'h0000, {15'h0, dec_valid});
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        // Held load only acts when the first instruction is taken
        pc_load <= 1'b1;
        pc_value <= 16'h0100;
        check_row(0);
        @(posedge ref_clk);
        pc_load <= 1'b0;
        for (int i = 17; i < 20; i++) begin
            check_row(i);
            @(posedge ref_clk);
        end
        summarize();
    end

    // Whole run needs about 300 cycles; this cuts a hang well after that
    initial begin
        #50000;
        n_errors++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
